// ===== emrq_pkg.sv
// Package for the memory-unit request qualifier block.
// Assumes a single processor clock shared by both units.
package emrq_pkg;
  localparam int ADDR_W   = 27;
  localparam int DATA_W   = 36;
  localparam int PAGE_W   = 9;
  localparam int BASE_W   = 14;
  localparam int OFFS_W   = 9;
  localparam int LEGACY_EXEC_TOP_BIT = 17;
  localparam logic [DATA_W-1:0] REG_RESET = 36'h0_0000_0000;
  localparam logic [2:0] STAGE_DIAG_CODE = 3'h7;
  localparam int RESP_DELAY_CYC = 1;

  typedef enum logic [1:0] {
    EMRQ_REG_NONE,
    EMRQ_REG_USER,
    EMRQ_REG_EXEC,
    EMRQ_REG_SWEEP
  } emrq_reg_sel_t;
endpackage

// ===== emrq_regsel_if.sv
// Interface carrying register selects and data between top and register file.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface emrq_regsel_if;
  logic                              load;
  emrq_pkg::emrq_reg_sel_t           sel;
  logic [emrq_pkg::DATA_W-1:0]       wdata;
  logic [emrq_pkg::DATA_W-1:0]       user_base;
  logic [emrq_pkg::DATA_W-1:0]       exec_base;
  logic [emrq_pkg::DATA_W-1:0]       sweep;
  modport top  (output load, output sel, output wdata,
                input user_base, input exec_base, input sweep);
  modport regs (input load, input sel, input wdata,
                output user_base, output exec_base, output sweep);
endinterface
`default_nettype wire

// ===== emrq_regs.sv
// Base and cache-sweep registers of the memory unit.
// Assumes a valid select is presented with each load pulse.
`timescale 1ns/1ps
`default_nettype none
module emrq_regs (
  input  wire logic   clock,
  input  wire logic   rst,
  emrq_regsel_if.regs rb
);
  typedef struct packed {
    logic [emrq_pkg::DATA_W-1:0] user_base;
    logic [emrq_pkg::DATA_W-1:0] exec_base;
    logic [emrq_pkg::DATA_W-1:0] sweep;
  } emrq_regs_t;

  emrq_regs_t state_reg;
  emrq_regs_t state_next;

  always_comb begin
    state_next = state_reg;
    if (rb.load) begin
      unique case (rb.sel)
        emrq_pkg::EMRQ_REG_USER:  state_next.user_base = rb.wdata;
        emrq_pkg::EMRQ_REG_EXEC:  state_next.exec_base = rb.wdata;
        emrq_pkg::EMRQ_REG_SWEEP: state_next.sweep     = rb.wdata;
        emrq_pkg::EMRQ_REG_NONE:  state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '{emrq_pkg::REG_RESET, emrq_pkg::REG_RESET, emrq_pkg::REG_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rb.user_base = state_reg.user_base;
  assign rb.exec_base = state_reg.exec_base;
  assign rb.sweep     = state_reg.sweep;
endmodule
`default_nettype wire

// ===== emrq_top.sv
// Memory-unit side of the execution/memory request qualifier interface: paging decision,
// protection checks, page-fault hold, physical address forming, cache use and the
// base and cache-sweep registers with their staging path.
// Assumes requests arrive on the shared processor clock, qualifiers held stable, and that
// the pager and cache lookup answer combinationally from the reference address.
// Summary of operation
// - Memory unit decides translation; legacy exec bypass.
// - Paging select high legacy, low extended.
// - Process table reference skips protection check.
// - User table address uses user base.
// - Exec table address uses exec base.
// - Forced page fault aborts request.
// - Private check on non-public translated page holds fault.
// - Cache peek returns hits regardless of cacheability.
// - Even-parity qualifier writes even directory parity.
// - Diagnostic cycle needs all other qualifiers clear.
// - Register load writes selected register.
// - Register read stages value for later fetch.
// - Service done raised after each request.
`timescale 1ns/1ps
`default_nettype none
module emrq_top #(
  parameter int DATA_W = emrq_pkg::DATA_W,
  parameter int ADDR_W = emrq_pkg::ADDR_W
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              service_req,
  input  wire logic [ADDR_W-1:0] ref_addr,
  input  wire logic [DATA_W-1:0] ref_wdata,
  input  wire logic              ref_write,
  input  wire logic              ref_may_be_translated,
  input  wire logic              legacy_paging_select,
  input  wire logic              user_space_ref,
  input  wire logic              process_table_ref,
  input  wire logic              user_table_ref,
  input  wire logic              exec_table_ref,
  input  wire logic              force_page_fault,
  input  wire logic              private_page_check,
  input  wire logic              address_break_hit,
  input  wire logic              cacheable_ref,
  input  wire logic              cache_peek,
  input  wire logic              dir_parity_even,
  input  wire logic              sysbus_diag_cycle,
  input  wire logic              reg_load_req,
  input  wire logic              reg_read_req,
  input  wire logic              user_base_sel,
  input  wire logic              exec_base_sel,
  input  wire logic              cache_sweep_sel,
  input  wire logic              fetch_staged_value,
  input  wire logic [2:0]        diag_select_code,
  input  wire logic              page_public_bit,
  input  wire logic              page_cacheable_bit,
  input  wire logic              page_access_ok,
  input  wire logic [ADDR_W-1:0] page_map_addr,
  input  wire logic              cache_hit,
  output logic                   service_done,
  output logic                   page_fault_hold,
  output logic                   ref_translated,
  output logic [ADDR_W-1:0]      physical_addr,
  output logic                   cache_use,
  output logic                   cache_fill,
  output logic                   dir_parity_even_out,
  output logic                   mem_write,
  output logic                   sysbus_diag_start,
  output logic                   qualifier_error,
  output logic [DATA_W-1:0]      staged_value,
  output logic [DATA_W-1:0]      fetch_data
);
  // All registered state; every output is read straight from it.
  typedef struct packed {
    logic              service_done;
    logic              page_fault_hold;
    logic              ref_translated;
    logic [ADDR_W-1:0] physical_addr;
    logic              cache_use;
    logic              cache_fill;
    logic              dir_parity_even;
    logic              mem_write;
    logic              diag_start;
    logic              qual_error;
    logic [DATA_W-1:0] staged;
    logic [DATA_W-1:0] fetch_data;
  } emrq_state_t;

  emrq_state_t state_reg;
  emrq_state_t state_next;

  // Base and cache-sweep registers live in their own module behind the interface.
  emrq_regsel_if rb ();

  emrq_regs u_regs (
    .clock (clock),
    .rst   (rst),
    .rb    (rb)
  );

  // Base register supplies the page frame; the offset comes from the address.
  // The frame and offset together are narrower than an address, so the top bits are zero.
  function automatic logic [ADDR_W-1:0] table_addr(input logic [DATA_W-1:0] base,
                                                   input logic [ADDR_W-1:0] addr);
    logic [emrq_pkg::BASE_W-1:0] frame;
    logic [emrq_pkg::OFFS_W-1:0] offset;
    frame      = base[emrq_pkg::BASE_W-1:0];
    offset     = addr[emrq_pkg::OFFS_W-1:0];
    table_addr = ADDR_W'({frame, offset});
  endfunction

  // Exactly one select line may accompany a register request.
  function automatic logic select_count_bad(input logic u,
                                            input logic e,
                                            input logic c);
    logic [1:0] count;
    count            = 2'({1'b0, u} + {1'b0, e} + {1'b0, c});
    select_count_bad = (count != 2'd1);
  endfunction

  // A cacheable reference may use the cache unless its translated page forbids it.
  function automatic logic cache_allowed(input logic cacheable,
                                         input logic translated,
                                         input logic page_cacheable);
    cache_allowed = cacheable && (!translated || page_cacheable);
  endfunction

  // Register chosen by a read request; with no valid select the staged value stays.
  function automatic logic [DATA_W-1:0] pick_reg(input emrq_pkg::emrq_reg_sel_t s,
                                                 input logic [DATA_W-1:0]     user_base,
                                                 input logic [DATA_W-1:0]     exec_base,
                                                 input logic [DATA_W-1:0]     sweep,
                                                 input logic [DATA_W-1:0]     keep);
    unique case (s)
      emrq_pkg::EMRQ_REG_USER:  pick_reg = user_base;
      emrq_pkg::EMRQ_REG_EXEC:  pick_reg = exec_base;
      emrq_pkg::EMRQ_REG_SWEEP: pick_reg = sweep;
      emrq_pkg::EMRQ_REG_NONE:  pick_reg = keep;
    endcase
  endfunction

  // User and exec table references build on their base register, translated ones take the pager's
  // frame, and the rest go out unchanged.
  function automatic logic [ADDR_W-1:0] phys_addr(input logic              user_tbl,
                                                  input logic              exec_tbl,
                                                  input logic              translated,
                                                  input logic [DATA_W-1:0] user_base,
                                                  input logic [DATA_W-1:0] exec_base,
                                                  input logic [ADDR_W-1:0] mapped,
                                                  input logic [ADDR_W-1:0] addr);
    if (user_tbl) begin
      phys_addr = table_addr(user_base, addr);
    end else if (exec_tbl) begin
      phys_addr = table_addr(exec_base, addr);
    end else if (translated) begin
      phys_addr = mapped;
    end else begin
      phys_addr = addr;
    end
  endfunction

  // Select decode; its priority only matters when the select count is already wrong.
  function automatic emrq_pkg::emrq_reg_sel_t decode_sel(input logic u,
                                                         input logic e,
                                                         input logic c);
    if (u) begin
      decode_sel = emrq_pkg::EMRQ_REG_USER;
    end else if (e) begin
      decode_sel = emrq_pkg::EMRQ_REG_EXEC;
    end else if (c) begin
      decode_sel = emrq_pkg::EMRQ_REG_SWEEP;
    end else begin
      decode_sel = emrq_pkg::EMRQ_REG_NONE;
    end
  endfunction

  // Combinational decode of the request standing at this edge.
  logic                    translate;
  logic                    legacy_bypass;
  logic                    prot_fail;
  logic                    fault;
  logic                    others_set;
  logic                    sel_bad;
  logic                    cache_ok;
  emrq_pkg::emrq_reg_sel_t sel;

  always_comb begin
    // Legacy mode leaves the low executive region untranslated.
    legacy_bypass = legacy_paging_select && !user_space_ref &&
                    !ref_addr[emrq_pkg::LEGACY_EXEC_TOP_BIT];
    translate     = ref_may_be_translated && !legacy_bypass;
    // Protection is only checked on translated references outside the process tables.
    prot_fail     = translate && !process_table_ref &&
                    (!page_access_ok || (private_page_check && !page_public_bit));
    fault         = force_page_fault || prot_fail;
    // Every line but the diagnostic strobe is a qualifier, mode and select lines included.
    others_set    = ref_write             ||
                    ref_may_be_translated ||
                    legacy_paging_select  ||
                    user_space_ref        ||
                    process_table_ref     ||
                    user_table_ref        ||
                    exec_table_ref        ||
                    force_page_fault      ||
                    private_page_check    ||
                    address_break_hit     ||
                    cacheable_ref         ||
                    cache_peek            ||
                    dir_parity_even       ||
                    reg_load_req          ||
                    reg_read_req          ||
                    user_base_sel         ||
                    exec_base_sel         ||
                    cache_sweep_sel;
    sel           = decode_sel(user_base_sel, exec_base_sel, cache_sweep_sel);
    sel_bad       = select_count_bad(user_base_sel, exec_base_sel, cache_sweep_sel);
    cache_ok      = cache_allowed(cacheable_ref, translate, page_cacheable_bit);

    // The register file only writes on a load strobe, so select and data may always flow.
    rb.load  = 1'b0;
    rb.sel   = sel;
    rb.wdata = ref_wdata;

    state_next                 = state_reg;
    state_next.service_done    = 1'b0;
    state_next.diag_start      = 1'b0;
    state_next.mem_write       = 1'b0;
    state_next.cache_fill      = 1'b0;

    // The fetch path is independent of requests and may run in the same cycle.
    if (fetch_staged_value && diag_select_code == emrq_pkg::STAGE_DIAG_CODE) begin
      state_next.fetch_data = state_reg.staged;
    end

    if (service_req) begin
      state_next.service_done = 1'b1;
      state_next.qual_error   = 1'b0;
      if (sysbus_diag_cycle) begin
        // A diagnostic cycle with any other qualifier set is refused outright.
        state_next.diag_start = !others_set;
        state_next.qual_error = others_set;
      end else if (reg_load_req || reg_read_req) begin
        // A load takes effect at this edge; a read in the same cycle sees the old value.
        state_next.qual_error = sel_bad;
        if (!sel_bad && reg_load_req) begin
          rb.load = 1'b1;
        end
        if (!sel_bad && reg_read_req) begin
          state_next.staged = pick_reg(sel, rb.user_base, rb.exec_base, rb.sweep,
                                       state_reg.staged);
        end
      end else begin
        // A faulted reference is aborted: no write and no cache traffic.
        state_next.page_fault_hold = fault;
        state_next.ref_translated  = translate;
        state_next.physical_addr   = phys_addr(user_table_ref, exec_table_ref, translate,
                                               rb.user_base, rb.exec_base,
                                               page_map_addr, ref_addr);
        if (!fault) begin
          state_next.mem_write       = ref_write;
          state_next.dir_parity_even = ref_write && dir_parity_even;
          // Peek returns any hit even when the item is marked uncacheable.
          state_next.cache_use  = cache_hit &&
                                  (cache_peek || cache_ok);
          state_next.cache_fill = !cache_hit &&
                                  cache_ok;
        end else begin
          state_next.cache_use       = 1'b0;
          state_next.dir_parity_even = 1'b0;
        end
      end
    end
  end

  // One register stage: results stand from the edge after the request.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign service_done        = state_reg.service_done;
  assign page_fault_hold     = state_reg.page_fault_hold;
  assign ref_translated      = state_reg.ref_translated;
  assign physical_addr       = state_reg.physical_addr;
  assign cache_use           = state_reg.cache_use;
  assign cache_fill          = state_reg.cache_fill;
  assign dir_parity_even_out = state_reg.dir_parity_even;
  assign mem_write           = state_reg.mem_write;
  assign sysbus_diag_start   = state_reg.diag_start;
  assign qualifier_error     = state_reg.qual_error;
  assign staged_value        = state_reg.staged;
  assign fetch_data          = state_reg.fetch_data;
endmodule
`default_nettype wire

// ===== emrq_assertions.sv
// Checker for the memory-unit request qualifier block.
// Assumes it is bound to emrq_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module emrq_assertions #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 27
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              service_req,
  input wire logic              ref_write,
  input wire logic              ref_may_be_translated,
  input wire logic              legacy_paging_select,
  input wire logic              user_space_ref,
  input wire logic              process_table_ref,
  input wire logic              force_page_fault,
  input wire logic              private_page_check,
  input wire logic              cacheable_ref,
  input wire logic              dir_parity_even,
  input wire logic              sysbus_diag_cycle,
  input wire logic              reg_load_req,
  input wire logic              reg_read_req,
  input wire logic              fetch_staged_value,
  input wire logic              page_public_bit,
  input wire logic              service_done,
  input wire logic              page_fault_hold,
  input wire logic              ref_translated,
  input wire logic              dir_parity_even_out,
  input wire logic              sysbus_diag_start,
  input wire logic              qualifier_error,
  input wire logic [2:0]        diag_select_code,
  input wire logic [ADDR_W-1:0] ref_addr,
  input wire logic [DATA_W-1:0] staged_value,
  input wire logic [DATA_W-1:0] fetch_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic mem_q;
  assign mem_q = service_req && !sysbus_diag_cycle && !reg_load_req && !reg_read_req;
  a_done_next: assert property (service_req |=> service_done)
    else $error("service_done missing after a request");
  a_done_idle: assert property (!service_req |=> !service_done)
    else $error("service_done without a request");
  a_forced_fault: assert property (mem_q && force_page_fault |=> page_fault_hold)
    else $error("forced fault did not hold");
  a_ext_translate: assert property (mem_q && ref_may_be_translated && !legacy_paging_select
    |=> ref_translated)
    else $error("extended mode reference not translated");
  a_legacy_bypass: assert property (mem_q && legacy_paging_select && !user_space_ref
    && !ref_addr[17] |=> !ref_translated)
    else $error("legacy exec reference translated");
  a_private_fault: assert property (mem_q && ref_may_be_translated && !legacy_paging_select
    && !process_table_ref && private_page_check && !page_public_bit |=> page_fault_hold)
    else $error("private page check did not hold");
  a_table_skip: assert property (mem_q && process_table_ref && !force_page_fault
    |=> !page_fault_hold)
    else $error("process table reference was checked");
  a_parity_even: assert property (mem_q && ref_write && dir_parity_even && !force_page_fault
    && !ref_may_be_translated |=> dir_parity_even_out)
    else $error("even parity not passed on");
  a_diag_refuse: assert property (service_req && sysbus_diag_cycle && cacheable_ref
    |=> qualifier_error && !sysbus_diag_start)
    else $error("diagnostic with qualifiers not refused");
  a_fetch_stage: assert property (fetch_staged_value && diag_select_code == 3'h7
    |=> fetch_data == $past(staged_value))
    else $error("fetch did not return staged value");
  c_fault: cover property (mem_q && force_page_fault);
  c_diag: cover property (service_req && sysbus_diag_cycle);
  c_fetch: cover property (fetch_staged_value && diag_select_code == 3'h7);
endmodule
bind emrq_top emrq_assertions #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (
  .clock, .rst, .service_req, .ref_write, .ref_may_be_translated, .legacy_paging_select,
  .user_space_ref, .process_table_ref, .force_page_fault, .private_page_check,
  .cacheable_ref, .dir_parity_even, .sysbus_diag_cycle, .reg_load_req, .reg_read_req,
  .fetch_staged_value, .page_public_bit, .service_done, .page_fault_hold, .ref_translated,
  .dir_parity_even_out, .sysbus_diag_start, .qualifier_error, .diag_select_code,
  .ref_addr, .staged_value, .fetch_data);
`default_nettype wire

// ===== emrq_pager.sv
// Pager and cache lookup model answering the memory unit's page tests.
// Assumes results follow the reference address combinationally.
`timescale 1ns/1ps
`default_nettype none
module emrq_pager (
  input  wire logic [26:0] ref_addr,
  output logic             page_public_bit,
  output logic             page_cacheable_bit,
  output logic             page_access_ok,
  output logic [26:0]      page_map_addr,
  output logic             cache_hit
);
  // Page attributes are spread over address bits so random addresses reach every case.
  always_comb begin
    page_public_bit    = ref_addr[20];
    page_access_ok     = !ref_addr[21];
    page_cacheable_bit = ref_addr[22];
    cache_hit          = ref_addr[23];
    page_map_addr      = ref_addr ^ 27'h2a5_5000;
  end
endmodule
`default_nettype wire

// ===== emrq_bench.sv
// Self-checking bench for the memory-unit request qualifier block.
// Assumes emrq_pkg, the register interface and the pager model compile first.
`timescale 1ns/1ps
`default_nettype none
module emrq_bench;
  typedef struct packed {
    logic [7:0] m, f;
    logic p, s;
    logic [26:0] pa;
    logic [35:0] sv;
  } emrq_note_t;
  logic clock = 1'b0, rst = 1'b1, service_req = 1'b0, fetch_staged_value = 1'b0;
  logic ref_write, ref_may_be_translated, legacy_paging_select, user_space_ref;
  logic process_table_ref, user_table_ref, exec_table_ref, force_page_fault, private_page_check;
  logic address_break_hit, cacheable_ref, cache_peek, dir_parity_even, sysbus_diag_cycle;
  logic reg_load_req, reg_read_req, user_base_sel, exec_base_sel, cache_sweep_sel, cache_hit;
  logic page_public_bit, page_cacheable_bit, page_access_ok, service_done, page_fault_hold;
  logic ref_translated, cache_use, cache_fill, dir_parity_even_out, mem_write;
  logic sysbus_diag_start, qualifier_error;
  logic [2:0]  diag_select_code = 3'h0;
  logic [26:0] ref_addr = 27'h0, page_map_addr, physical_addr;
  logic [35:0] ref_wdata = 36'h0, staged_value, fetch_data, regs [3];
  logic [18:0] v;
  emrq_note_t  notes [$], got;
  int          failures = 0, samples_checked = 0, i;
  emrq_top uut (.clock, .rst, .service_req, .ref_addr, .ref_wdata, .ref_write,
    .ref_may_be_translated, .legacy_paging_select, .user_space_ref, .process_table_ref,
    .user_table_ref, .exec_table_ref, .force_page_fault, .private_page_check,
    .address_break_hit, .cacheable_ref, .cache_peek, .dir_parity_even, .sysbus_diag_cycle,
    .reg_load_req, .reg_read_req, .user_base_sel, .exec_base_sel, .cache_sweep_sel,
    .fetch_staged_value, .diag_select_code, .page_public_bit, .page_cacheable_bit,
    .page_access_ok, .page_map_addr, .cache_hit, .service_done, .page_fault_hold,
    .ref_translated, .physical_addr, .cache_use, .cache_fill, .dir_parity_even_out,
    .mem_write, .sysbus_diag_start, .qualifier_error, .staged_value, .fetch_data);
  emrq_pager u_pager (.ref_addr, .page_public_bit, .page_cacheable_bit, .page_access_ok,
    .page_map_addr, .cache_hit);
  always #2 clock = ~clock;
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("samples_checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One request per call; the qualifiers stand for the whole request cycle.
  task automatic go(input logic [18:0] q, input logic [26:0] a, input logic [35:0] d);
    emrq_note_t n;
    logic oth, mem, tr, flt, elig;
    int k, r;
    {ref_write, ref_may_be_translated, legacy_paging_select, user_space_ref, process_table_ref,
     user_table_ref, exec_table_ref, force_page_fault, private_page_check, address_break_hit,
     cacheable_ref, cache_peek, dir_parity_even, sysbus_diag_cycle, reg_load_req, reg_read_req,
     user_base_sel, exec_base_sel, cache_sweep_sel} = q;
    ref_addr = a;
    ref_wdata = d;
    service_req = 1'b1;
    oth = |(q & 19'h7_ffdf);
    k = q[2] + q[1] + q[0];
    r = q[1] ? 1 : (q[0] ? 2 : 0);
    mem = !q[5] && !q[4] && !q[3];
    tr = mem && q[17] && !(q[16] && !q[15] && !a[17]);
    flt = mem && (q[11] || (tr && !q[14] && (a[21] || (q[10] && !a[20]))));
    elig = q[8] && (!tr || a[22]);
    n = '0;
    n.m = mem ? 8'hff : 8'h63;
    n.f = {mem && !flt && a[23] && (q[7] || elig), mem && !flt && !a[23] && elig,
           mem && !flt && q[18], flt, tr, mem && !flt && q[18] && q[6],
           q[5] ? oth : (!mem && k != 1), q[5] && !oth};
    n.p = mem;
    n.pa = (q[13] || q[12]) ? {4'h0, regs[q[13] ? 0 : 1][13:0], a[8:0]} :
           (tr ? a ^ 27'h2a5_5000 : a);
    n.s = q[3] && !q[5] && k == 1;
    n.sv = regs[r];
    if (q[4] && !q[5] && k == 1) regs[r] = d;
    notes.push_back(n);
    @(negedge clock);
  endtask
  always @(negedge clock) begin
    if (service_done === 1'b1) begin
      got = notes.pop_front();
      check("flags", 36'({cache_use, cache_fill, mem_write, page_fault_hold, ref_translated,
        dir_parity_even_out, qualifier_error, sysbus_diag_start} & got.m),
        36'(got.f & got.m));
      if (got.p) check("physical_addr", 36'(physical_addr), 36'(got.pa));
      if (got.s) check("staged_value", staged_value, got.sv);
    end
  end
  initial begin
    void'($urandom(32'h8374_f829));
    regs = '{3{emrq_pkg::REG_RESET}};
    go(19'h0_0000, 27'h0, 36'h0);
    repeat (11) @(negedge clock);
    rst = 1'b0;
    service_req = 1'b0;
    notes.delete();
    check("done after reset", 36'(service_done), 36'h0);
    for (i = 0; i < 60; i++) begin
      v = 19'($urandom) & 19'h7_ffc0;
      v[11] = v[11] | v[9];
      go(v, 27'($urandom), 36'h0);
    end
    for (i = 0; i < 3; i++) go(19'h0_0010 | (19'h0_0004 >> i), 27'h0,
      36'({$urandom, $urandom}));
    go(19'h0_6000, 27'($urandom), 36'h0);
    go(19'h0_5000, 27'($urandom), 36'h0);
    go(19'h0_0016, 27'h0, 36'h0);
    go(19'h0_0008, 27'h0, 36'h0);
    go(19'h0_0020, 27'h0, 36'h0);
    go(19'h0_0120, 27'h0, 36'h0);
    for (i = 0; i < 3; i++) go(19'h0_0008 | (19'h0_0004 >> i), 27'h0, 36'h0);
    service_req = 1'b0;
    fetch_staged_value = 1'b1;
    diag_select_code = 3'h7;
    @(negedge clock);
    fetch_staged_value = 1'b0;
    @(negedge clock);
    check("fetch_data", fetch_data, regs[2]);
    for (i = 0; i < 20 && notes.size() > 0; i++) @(negedge clock);
    check("answers pending", 36'(notes.size()), 36'h0);
    summarize();
  end
endmodule
`default_nettype wire
